// [shared/shp_defines.vh]
// Constants for the slave controller host port
`ifndef SHP_DEFINES_VH
`define SHP_DEFINES_VH
// Host status byte bit positions
`define SHP_STAT_OBF_BIT   0
`define SHP_STAT_IBF_BIT   1
`define SHP_STAT_CMD_BIT   3
// Reset values
`define SHP_RST_BYTE       8'h00
`define SHP_RST_PORT       8'hFF
// Operation codes on the internal command port
`define SHP_OP_NONE        4'h0
`define SHP_OP_IN_DBB      4'h1
`define SHP_OP_OUT_DBB     4'h2
`define SHP_OP_J_IN_EMPTY  4'h3
`define SHP_OP_J_OUT_FULL  4'h4
`define SHP_OP_J_TIMER     4'h5
`define SHP_OP_J_T0        4'h6
`define SHP_OP_J_T1        4'h7
`define SHP_OP_EXP_READ    4'h8
`define SHP_OP_EXP_WRITE   4'h9
`define SHP_OP_EXP_AND     4'hA
`define SHP_OP_EXP_OR      4'hB
`define SHP_OP_PORT_OUT1   4'hC
`define SHP_OP_PORT_OUT2   4'hD
// Instruction cycle length in clocks
`define SHP_CYCLE_CLKS     15
// Expander nibble codes
`define SHP_EXP_RD         2'h0
`define SHP_EXP_WR         2'h1
`define SHP_EXP_OR         2'h2
`define SHP_EXP_AND        2'h3
`endif

// [sim/shp_host_port_bench.sv]
// Self-checking bench for the host port block
`default_nettype none
`include "shp_defines.vh"
module shp_host_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       i_clk = 1'b0;
  logic       i_nrst = 1'b0;
  logic       cs_n, rd_n, wr_n, sel, oe, rdy, ld, tk, dn, input_full_flag, output_full_flag, stb;
  logic       vld = 1'b0, t0 = 1'b0, t1 = 1'b0;
  logic [7:0] di, dout, acc_o, p1, p2, b, r;
  logic [7:0] acc = 8'h00;
  logic [3:0] op = 4'h0, nib;
  logic [1:0] ep = 2'h0;
  logic [9:0] pc, ba = 10'h000;
  logic       syn, xoe, tfl;
  logic       stm = 1'b0, stn = 1'b1, cm = 1'b0, run = 1'b0;
  logic [7:0] po1, po2, tmr;
  logic [9:0] nsy;
  localparam int CYC = 4;
  integer     fail_count = 0, checks_done = 0, seed = 30, cyc = 0;
  integer     m_ibf = 0, m_obf = 0, m_cmd = 0, m_pc = 0, i;
  always #5 i_clk = ~i_clk;
  shp_host_port #(.CYCLE_CLKS(CYC)) DUT (
    .i_clk, .i_nrst, .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n),
    .i_data_command_select(sel), .i_data(di), .o_data(dout), .o_data_oe(oe),
    .i_step_mode(stm), .i_step_n(stn), .o_sync(syn), .i_op(op), .i_acc(acc),
    .i_exp_port(ep), .i_op_valid(vld), .o_op_ready(rdy), .o_acc(acc_o),
    .o_acc_load(ld), .o_branch_taken(tk), .o_op_done(dn), .o_pc(pc),
    .i_branch_addr(ba), .i_counter_mode(cm), .i_timer_run(run),
    .i_test_input_zero(t0), .i_test_input_one(t1), .o_timer_flag(tfl), .o_timer(tmr),
    .i_port1(p1), .i_port2(p2), .o_port1(po1), .o_port2(po2), .i_expander_nibble(nib),
    .o_expander_nibble(), .o_expander_nibble_oe(xoe), .o_prog_strobe(stb),
    .o_input_full_flag(input_full_flag), .o_output_full_flag(output_full_flag)
  );
  shp_master_model M (.i_clk, .i_bus(dout), .i_bus_oe(oe), .o_cs_n(cs_n),
    .o_rd_n(rd_n), .o_wr_n(wr_n), .o_sel(sel), .o_bus(di));
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [9:0] g, input logic [9:0] e);
    checks_done = checks_done + 1;
    if (g !== e) begin
      fail_count = fail_count + 1;
      $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
    end
  endtask
  function automatic logic [7:0] stat();
    return 8'((m_cmd << `SHP_STAT_CMD_BIT) | (m_ibf << `SHP_STAT_IBF_BIT) |
              (m_obf << `SHP_STAT_OBF_BIT));
  endfunction
  // Issue one op, wait for done, compare branch and program counter
  task automatic do_op(input logic [3:0] o, input integer j, input integer e);
    integer n;
    n = 0;
    @(posedge i_clk);
    #1;
    op = o;
    acc = 8'($random(seed));
    ep = 2'($random(seed));
    ba = 10'($random(seed));
    vld = 1'b1;
    while (rdy !== 1'b1 && n < 50) begin
      @(posedge i_clk);
      #1;
      n = n + 1;
    end
    @(posedge i_clk);
    #1;
    vld = 1'b0;
    while (dn !== 1'b1 && n < 100) begin
      @(posedge i_clk);
      #1;
      n = n + 1;
    end
    chk(dn, 1'b1);
    chk({ld, xoe, stb}, {o == `SHP_OP_IN_DBB || o == `SHP_OP_EXP_READ, 2'b01});
    if (j != 0)
      chk(tk, e);
    m_pc = (j != 0 && e != 0) ? ba : (m_pc + 1 + j) % 1024;
    chk(pc, m_pc);
  endtask
  // Hang guard on the cycle count
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      give_verdict();
    end
  end
  // Main sequence
  initial begin
    p1 = 8'($random(seed));
    p2 = 8'($random(seed));
    nib = 4'($random(seed));
    repeat (6) @(posedge i_clk);
    #1;
    i_nrst = 1'b1;
    chk({input_full_flag, output_full_flag, oe, stb}, 4'h1);
    chk(pc, 0);
    chk(po1, `SHP_RST_PORT);
    chk(po2, `SHP_RST_PORT);
    M.wr(1'b0, 8'($random(seed)), 1'b1);
    m_ibf = 1;
    M.rd(1'b1, r);
    chk(r, stat());
    b = 8'($random(seed));
    M.wr(1'b1, b, 1'b1);
    m_cmd = 1;
    M.wr(1'b0, ~b, 1'b0);
    M.rd(1'b1, r);
    chk(r, stat());
    do_op(`SHP_OP_J_IN_EMPTY, 1, 0);
    do_op(`SHP_OP_IN_DBB, 0, 0);
    m_ibf = 0;
    chk(acc_o, b);
    do_op(`SHP_OP_J_IN_EMPTY, 1, 1);
    do_op(`SHP_OP_OUT_DBB, 0, 0);
    b = acc;
    m_obf = 1;
    M.rd(1'b1, r);
    chk(r, stat());
    do_op(`SHP_OP_J_OUT_FULL, 1, 1);
    M.rd(1'b0, r);
    chk(r, b);
    m_obf = 0;
    M.rd(1'b1, r);
    chk(r, stat());
    do_op(`SHP_OP_J_OUT_FULL, 1, 0);
    for (i = 0; i < 4; i = i + 1) begin
      do_op(4'(`SHP_OP_EXP_READ + i), 0, 0);
      if (i == 0)
        chk(acc_o, {4'h0, nib});
      t0 = i[0];
      t1 = i[1];
      do_op(`SHP_OP_J_T0, 1, i % 2);
      do_op(`SHP_OP_J_T1, 1, i / 2);
    end
    // Port latches take the accumulator
    do_op(`SHP_OP_PORT_OUT1, 0, 0);
    chk(po1, acc);
    do_op(`SHP_OP_PORT_OUT2, 0, 0);
    chk(po2, acc);
    // Counter on test input one rises up to overflow
    t1 = 1'b0;
    cm = 1'b1;
    run = 1'b1;
    for (i = 0; i < 256; i = i + 1) begin
      @(posedge i_clk);
      #1;
      t1 = 1'b1;
      @(posedge i_clk);
      #1;
      t1 = 1'b0;
      if (i == 254)
        chk({tfl, tmr}, 9'h0FF);
    end
    chk({tfl, tmr}, 9'h100);
    run = 1'b0;
    cm = 1'b0;
    do_op(`SHP_OP_J_TIMER, 1, 1);
    chk(tfl, 1'b0);
    do_op(`SHP_OP_J_TIMER, 1, 0);
    // Timer mode counts one per instruction cycle
    run = 1'b1;
    repeat (40) @(posedge i_clk);
    #1;
    run = 1'b0;
    chk(tmr, 10'(40 / CYC));
    // Free run strobes once per cycle
    nsy = 10'h000;
    repeat (16) begin
      @(posedge i_clk);
      #1;
      nsy = nsy + syn;
    end
    chk(nsy, 10'(16 / CYC));
    // Single step holds the strobe until a step request
    stm = 1'b1;
    nsy = 10'h000;
    repeat (12) begin
      @(posedge i_clk);
      #1;
      nsy = nsy + syn;
    end
    chk(nsy, 0);
    stn = 1'b0;
    repeat (8) begin
      @(posedge i_clk);
      #1;
      stn = 1'b1;
      nsy = nsy + syn;
    end
    chk(nsy, 1);
    stm = 1'b0;
    give_verdict();
  end
endmodule // shp_host_port_bench
`default_nettype wire

// [sim/shp_host_port_chk.sv]
// Checker on the host port pins and op handshake
`default_nettype none
`include "shp_defines.vh"
module shp_host_port_chk #(
  parameter int CYCLE_CLKS = `SHP_CYCLE_CLKS
) (
  input wire logic       i_clk,
  input wire logic       i_nrst,
  input wire logic       i_cs_n,
  input wire logic       i_rd_n,
  input wire logic       i_wr_n,
  input wire logic       i_data_command_select,
  input wire logic [7:0] o_data,
  input wire logic       o_data_oe,
  input wire logic       o_sync,
  input wire logic [3:0] i_op,
  input wire logic [1:0] i_exp_port,
  input wire logic       i_op_valid,
  input wire logic       o_op_ready,
  input wire logic       o_op_done,
  input wire logic       o_branch_taken,
  input wire logic [9:0] o_pc,
  input wire logic [3:0] o_expander_nibble,
  input wire logic       o_prog_strobe,
  input wire logic       o_input_full_flag,
  input wire logic       o_output_full_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tk;
  logic jmp_reg = 1'b0;
  logic want_reg = 1'b0;
  int   gap_reg = 0;
  // Op accepted at this edge
  assign tk = i_op_valid && o_op_ready;
  // Flag jump kind and expected branch latched at take
  always @(posedge i_clk) begin
    gap_reg <= o_sync ? 0 : gap_reg + 1;
    if (tk) begin
      jmp_reg <= i_op == `SHP_OP_J_IN_EMPTY || i_op == `SHP_OP_J_OUT_FULL;
      want_reg <= i_op == `SHP_OP_J_IN_EMPTY ? !o_input_full_flag : o_output_full_flag;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  a_bus_read_only: assert property (o_data_oe |-> $past(!i_cs_n && !i_rd_n))
    else $error("bus driven outside a read");
  a_status_shape: assert property (o_data_oe && $past(o_data_oe && i_data_command_select)
    |-> o_data[7:4] == 4'h0 && !o_data[2]) else $error("bad status byte");
  a_write_sets_full: assert property ($rose(i_wr_n) && $past(!i_cs_n)
    |-> ##[1:2] o_input_full_flag) else $error("write did not set input flag");
  a_unselected_quiet: assert property (!o_input_full_flag && i_cs_n && $past(i_cs_n)
    && $past(i_cs_n, 2) |=> !o_input_full_flag) else $error("flag set without select");
  a_sync_spacing: assert property (o_sync |-> gap_reg >= CYCLE_CLKS - 1 ##1 !o_sync)
    else $error("cycle strobe too close");
  a_in_done: assert property (tk && i_op == `SHP_OP_IN_DBB
    |=> o_op_done && !o_input_full_flag) else $error("buffer-in result wrong");
  a_out_done: assert property (tk && i_op == `SHP_OP_OUT_DBB
    |=> o_op_done && o_output_full_flag) else $error("buffer-out result wrong");
  a_jump_outcome: assert property (o_op_done && jmp_reg |-> o_branch_taken == want_reg)
    else $error("flag jump outcome wrong");
  a_exp_nibble: assert property (tk && i_op == `SHP_OP_EXP_WRITE
    |=> o_expander_nibble == {`SHP_EXP_WR, $past(i_exp_port)} ##1 !o_prog_strobe)
    else $error("expander nibble or strobe wrong");
  a_reset_state: assert property (disable iff (1'b0) !i_nrst
    |=> !o_input_full_flag && !o_output_full_flag && o_pc == 10'h000 && !o_data_oe)
    else $error("reset state wrong");
endmodule // shp_host_port_chk
bind shp_host_port shp_host_port_chk #(.CYCLE_CLKS(CYCLE_CLKS)) CHK (
  .i_clk, .i_nrst, .i_cs_n, .i_rd_n, .i_wr_n, .i_data_command_select, .o_data, .o_data_oe,
  .o_sync, .i_op, .i_exp_port, .i_op_valid, .o_op_ready, .o_op_done, .o_branch_taken, .o_pc,
  .o_expander_nibble, .o_prog_strobe, .o_input_full_flag, .o_output_full_flag
);
`default_nettype wire

// [sim/shp_master_model.sv]
// Master processor model on the host data bus
`default_nettype none
module shp_master_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_bus,
  input  wire logic       i_bus_oe,
  output logic            o_cs_n = 1'b1,
  output logic            o_rd_n = 1'b1,
  output logic            o_wr_n = 1'b1,
  output logic            o_sel = 1'b0,
  output logic [7:0]      o_bus
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last = 8'h00;
  logic       drv = 1'b0;
  // Wire level: our byte, the device byte, else inverted junk
  assign o_bus = drv ? last : (i_bus_oe ? i_bus : ~last);
  task automatic wr(input logic s, input logic [7:0] b, input logic en);
    @(posedge i_clk);
    #1;
    o_cs_n = !en;
    o_sel = s;
    last = b;
    drv = 1'b1;
    o_wr_n = 1'b0;
    repeat (2) @(posedge i_clk);
    #1;
    o_wr_n = 1'b1;
    @(posedge i_clk);
    #1;
    o_cs_n = 1'b1;
    drv = 1'b0;
  endtask
  // read cycle, byte taken while driven
  task automatic rd(input logic s, output logic [7:0] b);
    @(posedge i_clk);
    #1;
    o_cs_n = 1'b0;
    o_sel = s;
    o_rd_n = 1'b0;
    repeat (2) @(posedge i_clk);
    b = i_bus_oe ? i_bus : 8'hXX;
    #1;
    o_rd_n = 1'b1;
    o_cs_n = 1'b1;
  endtask
endmodule // shp_master_model
`default_nettype wire

// [src/shp_cycle_gen.v]
// Instruction cycle divider with single-step gating
`default_nettype none
`include "shp_defines.vh"
module shp_cycle_gen #(
  parameter CYCLE_CLKS = `SHP_CYCLE_CLKS
) (
  input  wire       i_clk,
  input  wire       i_nrst,
  input  wire       i_step_mode,
  input  wire       i_step_n,
  output reg        o_cycle_en,
  output reg        o_sync
);
  reg  [7:0] div_reg;
  reg        step_d_reg;
  reg        armed_reg;
  wire       wrap;
  wire       step_fall;

  assign wrap      = (div_reg == CYCLE_CLKS[7:0] - 8'h01);
  assign step_fall = step_d_reg & ~i_step_n;

  // Divider, step arming and strobe pulse
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      div_reg    <= 8'h00;
      step_d_reg <= 1'b1;
      armed_reg  <= 1'b0;
      o_cycle_en <= 1'b0;
      o_sync     <= 1'b0;
    end else begin
      step_d_reg <= i_step_n;
      o_cycle_en <= 1'b0;
      o_sync     <= 1'b0;
      if (step_fall)
        armed_reg <= 1'b1;
      if (wrap) begin
        div_reg <= 8'h00;
        if (!i_step_mode || armed_reg || step_fall) begin
          o_cycle_en <= 1'b1;
          o_sync     <= 1'b1;
          armed_reg  <= 1'b0;
        end
      end else begin
        div_reg <= div_reg + 8'h01;
      end
    end
  end
endmodule // shp_cycle_gen
`default_nettype wire

// [src/shp_host_port.v]
// Host data buffer port, flags, test branches and expander strobe
`default_nettype none
`include "shp_defines.vh"
module shp_host_port #(
  parameter CYCLE_CLKS = `SHP_CYCLE_CLKS
) (
  input  wire       i_clk,
  input  wire       i_nrst,
  input  wire       i_cs_n,
  input  wire       i_rd_n,
  input  wire       i_wr_n,
  input  wire       i_data_command_select,
  input  wire [7:0] i_data,
  output wire [7:0] o_data,
  output wire       o_data_oe,
  input  wire       i_step_mode,
  input  wire       i_step_n,
  output wire       o_sync,
  input  wire [3:0] i_op,
  input  wire [7:0] i_acc,
  input  wire [1:0] i_exp_port,
  input  wire       i_op_valid,
  output wire       o_op_ready,
  output reg  [7:0] o_acc,
  output reg        o_acc_load,
  output reg        o_branch_taken,
  output reg        o_op_done,
  output reg  [9:0] o_pc,
  input  wire [9:0] i_branch_addr,
  input  wire       i_counter_mode,
  input  wire       i_timer_run,
  input  wire       i_test_input_zero,
  input  wire       i_test_input_one,
  output reg        o_timer_flag,
  output reg  [7:0] o_timer,
  input  wire [7:0] i_port1,
  input  wire [7:0] i_port2,
  output reg  [7:0] o_port1,
  output reg  [7:0] o_port2,
  input  wire [3:0] i_expander_nibble,
  output reg  [3:0] o_expander_nibble,
  output reg        o_expander_nibble_oe,
  output reg        o_prog_strobe,
  output wire       o_input_full_flag,
  output wire       o_output_full_flag
);
  localparam ST_IDLE = 2'h0;
  localparam ST_EXP1 = 2'h1;
  localparam ST_EXP2 = 2'h2;
  localparam ST_JMP2 = 2'h3;

  reg  [7:0] in_buf_reg;
  reg  [7:0] out_buf_reg;
  reg        ibf_reg;
  reg        obf_reg;
  reg        cmd_reg;
  reg        wr_d_reg;
  reg        rd_d_reg;
  reg        t1_d_reg;
  reg  [7:0] read_reg;
  reg        read_oe_reg;
  reg  [1:0] state_reg;
  reg  [3:0] op_reg;
  reg  [7:0] acc_reg;
  reg  [1:0] port_reg;
  reg        take_reg;
  reg  [3:0] nib_reg;
  wire       cycle_en;
  wire       sel;
  wire       wr_end;
  wire       rd_start;
  wire       rd_end;
  wire       t1_rise;
  wire       ibf_clr;
  wire       obf_set;
  wire       tf_clr;
  wire       tick;
  wire [7:0] status;

  // Expander code for an operation
  function [1:0] exp_code;
    input [3:0] op;
    begin
      case (op)
        `SHP_OP_EXP_WRITE: exp_code = `SHP_EXP_WR;
        `SHP_OP_EXP_AND:   exp_code = `SHP_EXP_AND;
        `SHP_OP_EXP_OR:    exp_code = `SHP_EXP_OR;
        default:           exp_code = `SHP_EXP_RD;
      endcase
    end
  endfunction

  shp_cycle_gen #(
    .CYCLE_CLKS (CYCLE_CLKS)
  ) u_cycle (
    .i_clk       (i_clk),
    .i_nrst      (i_nrst),
    .i_step_mode (i_step_mode),
    .i_step_n    (i_step_n),
    .o_cycle_en  (cycle_en),
    .o_sync      (o_sync)
  );

  assign sel      = ~i_cs_n;
  assign wr_end   = ~wr_d_reg & (i_wr_n | i_cs_n);
  assign rd_start = sel & rd_d_reg & ~i_rd_n;
  assign rd_end   = ~rd_d_reg & i_rd_n;
  assign t1_rise  = i_test_input_one & ~t1_d_reg;
  assign status   = {4'h0, cmd_reg, 1'b0, ibf_reg, obf_reg};
  assign o_input_full_flag  = ibf_reg;
  assign o_output_full_flag = obf_reg;
  assign o_op_ready = (state_reg == ST_IDLE) & cycle_en;
  assign ibf_clr = o_op_ready & i_op_valid & (i_op == `SHP_OP_IN_DBB);
  assign obf_set = o_op_ready & i_op_valid & (i_op == `SHP_OP_OUT_DBB);
  assign tf_clr  = o_op_ready & i_op_valid & (i_op == `SHP_OP_J_TIMER);
  assign tick = i_timer_run & (i_counter_mode ? t1_rise : cycle_en);
  assign o_data    = read_reg;
  assign o_data_oe = read_oe_reg;

  // Host side strobes, buffers and flags
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      in_buf_reg  <= `SHP_RST_BYTE;
      out_buf_reg <= `SHP_RST_BYTE;
      ibf_reg     <= 1'b0;
      obf_reg     <= 1'b0;
      cmd_reg     <= 1'b0;
      wr_d_reg    <= 1'b1;
      rd_d_reg    <= 1'b1;
      read_reg    <= `SHP_RST_BYTE;
      read_oe_reg <= 1'b0;
    end else begin
      wr_d_reg <= i_wr_n | i_cs_n;
      rd_d_reg <= i_rd_n | i_cs_n;
      if (sel & ~i_wr_n) begin
        in_buf_reg <= i_data;
        cmd_reg    <= i_data_command_select;
      end
      if (wr_end)
        ibf_reg <= 1'b1;
      else if (ibf_clr)
        ibf_reg <= 1'b0;
      if (rd_start) begin
        read_oe_reg <= 1'b1;
        read_reg    <= i_data_command_select ? status : out_buf_reg;
      end else if (rd_end | i_cs_n) begin
        read_oe_reg <= 1'b0;
      end
      if (obf_set) begin
        out_buf_reg <= i_acc;
        obf_reg     <= 1'b1;
      end else if (rd_end & ~i_data_command_select & read_oe_reg) begin
        obf_reg <= 1'b0;
      end
    end
  end

  // Timer and counter with overflow flag
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      t1_d_reg     <= i_test_input_one; // No false edge after reset
      o_timer      <= `SHP_RST_BYTE;
      o_timer_flag <= 1'b0;
    end else begin
      t1_d_reg <= i_test_input_one;
      if (tick)
        o_timer <= o_timer + 8'h01;
      if (tick && o_timer == 8'hFF)
        o_timer_flag <= 1'b1;
      else if (tf_clr)
        o_timer_flag <= 1'b0;
    end
  end

  // Internal operation sequencer
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      state_reg            <= ST_IDLE;
      op_reg               <= `SHP_OP_NONE;
      acc_reg              <= `SHP_RST_BYTE;
      port_reg             <= 2'h0;
      take_reg             <= 1'b0;
      nib_reg              <= 4'h0;
      o_acc                <= `SHP_RST_BYTE;
      o_acc_load           <= 1'b0;
      o_branch_taken       <= 1'b0;
      o_op_done            <= 1'b0;
      o_pc                 <= 10'h000;
      o_port1              <= `SHP_RST_PORT;
      o_port2              <= `SHP_RST_PORT;
      o_expander_nibble    <= 4'h0;
      o_expander_nibble_oe <= 1'b0;
      o_prog_strobe        <= 1'b1;
    end else begin
      o_acc_load     <= 1'b0;
      o_branch_taken <= 1'b0;
      o_op_done      <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (o_op_ready && i_op_valid) begin
            op_reg   <= i_op;
            acc_reg  <= i_acc;
            port_reg <= i_exp_port;
            o_pc     <= o_pc + 10'h001;
            case (i_op)
              `SHP_OP_IN_DBB: begin
                o_acc      <= in_buf_reg;
                o_acc_load <= 1'b1;
                o_op_done  <= 1'b1;
              end
              `SHP_OP_PORT_OUT1: begin
                o_port1   <= i_acc;
                o_op_done <= 1'b1;
              end
              `SHP_OP_PORT_OUT2: begin
                o_port2   <= i_acc;
                o_op_done <= 1'b1;
              end
              `SHP_OP_J_IN_EMPTY: begin
                take_reg  <= ~ibf_reg;
                state_reg <= ST_JMP2;
              end
              `SHP_OP_J_OUT_FULL: begin
                take_reg  <= obf_reg;
                state_reg <= ST_JMP2;
              end
              `SHP_OP_J_TIMER: begin
                take_reg  <= o_timer_flag;
                state_reg <= ST_JMP2;
              end
              `SHP_OP_J_T0: begin
                take_reg  <= i_test_input_zero;
                state_reg <= ST_JMP2;
              end
              `SHP_OP_J_T1: begin
                take_reg  <= i_test_input_one;
                state_reg <= ST_JMP2;
              end
              `SHP_OP_EXP_READ, `SHP_OP_EXP_WRITE,
              `SHP_OP_EXP_AND, `SHP_OP_EXP_OR: begin
                o_expander_nibble    <= {exp_code(i_op), i_exp_port};
                o_expander_nibble_oe <= 1'b1;
                state_reg            <= ST_EXP1;
              end
              default: begin
                o_op_done <= 1'b1;
              end
            endcase
          end
        end
        ST_EXP1: begin
          o_prog_strobe <= 1'b0;
          if (op_reg == `SHP_OP_EXP_READ) begin
            o_expander_nibble_oe <= 1'b0;
          end else begin
            o_expander_nibble <= acc_reg[3:0];
          end
          state_reg <= ST_EXP2;
        end
        ST_EXP2: begin
          if (cycle_en) begin
            o_prog_strobe        <= 1'b1;
            o_expander_nibble_oe <= 1'b0;
            if (op_reg == `SHP_OP_EXP_READ) begin
              o_acc      <= {4'h0, i_expander_nibble};
              o_acc_load <= 1'b1;
            end
            o_op_done <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        ST_JMP2: begin
          if (cycle_en) begin
            if (take_reg) begin
              o_pc           <= i_branch_addr;
              o_branch_taken <= 1'b1;
            end else begin
              o_pc <= o_pc + 10'h001;
            end
            o_op_done <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // shp_host_port
`default_nettype wire
